// File: verilog/phy_mode_pkg.sv
// constants for the transceiver strap and mode control block
package phy_mode_pkg;
   // register indices (management address space)
   localparam logic [4:0] CTRL_ADDR = 5'h00;
   localparam logic [4:0] STAT_ADDR = 5'h01;
   localparam logic [4:0] ADV_ADDR  = 5'h04;
   localparam logic [4:0] VEND_ADDR = 5'h10;
   // control register fields
   localparam int CTRL_RESET_BIT   = 15;
   localparam int CTRL_SPEED_BIT   = 13;
   localparam int CTRL_ANEN_BIT    = 12;
   localparam int CTRL_POWER_DOWN_BIT   = 11;
   localparam int CTRL_ISO_BIT     = 10;
   localparam int CTRL_DUPLEX_BIT  = 8;
   // status register fields
   localparam int STAT_T4_BIT      = 15;
   localparam int STAT_ABIL_LSB    = 11;
   localparam int STAT_AUTONEG_ABILITY_STRAP_BIT   = 3;
   localparam int STAT_EXT_BIT     = 0;
   // advertisement fields
   localparam int ADV_ABIL_LSB     = 5;
   localparam logic [4:0] ADV_SELECTOR = 5'h01;
   // vendor register fields
   localparam int VEND_REPEATER_MODE_BIT    = 15;
   localparam logic [15:0] VEND_RESET = 16'h0000;
   // technology strap code for full ability
   localparam logic [2:0] TECH_ALL = 3'h7;
   // power-on reset stretch
   localparam int POR_NS     = 100;
   localparam int CLK_NS     = 4;
   localparam int POR_CYCLES = (POR_NS + CLK_NS - 1) / CLK_NS;
endpackage

// File: verilog/phy_mode_ctrl.sv
// strap, reset and mode control of a 10/100 transceiver
//
// Design decisions made here: the register addresses and the address-and-strobe port.
module phy_mode_ctrl
   import phy_mode_pkg::*;
(
   // clock and reset
   input  wire logic        sys_clk_i,
   input  wire logic        rst_i,
   // straps and mode pins
   input  wire logic        power_down_i,
   input  wire logic        isolate_i,
   input  wire logic        isolate_default_strap_i,
   input  wire logic        autoneg_ability_strap_i,
   input  wire logic [2:0]  technology_select_strap_i,
   input  wire logic        repeater_mode_i,
   // register port
   input  wire logic [4:0]  reg_addr_i,
   input  wire logic [15:0] reg_wdata_i,
   input  wire logic        reg_wr_i,
   input  wire logic        reg_rd_i,
   output logic      [15:0] reg_rdata_o,
   // activity from the datapath
   input  wire logic        tx_active_i,
   input  wire logic        rx_active_i,
   input  wire logic        collision_i,
   input  wire logic        sqe_test_i,
   // mode outputs
   output logic             chip_reset_o,
   output logic             power_down_o,
   output logic             autoneg_enable_o,
   output logic             speed_100_o,
   output logic             full_duplex_o,
   output logic             repeater_o,
   // MII output enables (low = driving) and carrier/collision
   output logic             mii_oe_n_o,
   output logic             crs_o,
   output logic             col_o
);

   logic [$clog2(POR_CYCLES+1)-1:0] por_cnt_reg;
   logic        por_done_reg;
   logic        soft_rst_reg;
   logic        int_rst;
   logic [15:0] ctrl_reg;
   logic [15:0] vend_reg;
   logic [3:0]  abil;
   logic        pd_mode;
   logic        iso_mode;
   logic        rpt_mode;

   // ability set per strap code: {100FD,100HD,10FD,10HD}
   function automatic logic [3:0] tech_abil(input logic [2:0] code);
      case (code)
         3'h0:    tech_abil = 4'h0;
         3'h1:    tech_abil = 4'h1;
         3'h2:    tech_abil = 4'h4;
         3'h3:    tech_abil = 4'h5;
         3'h4:    tech_abil = 4'h3;
         3'h5:    tech_abil = 4'hC;
         3'h6:    tech_abil = 4'h0;
         TECH_ALL: tech_abil = 4'hF;
         default: tech_abil = 4'h0;
      endcase
   endfunction

   // repeater mode drops full-duplex abilities
   assign abil     = tech_abil(technology_select_strap_i) & (rpt_mode ? 4'h5 : 4'hF);
   assign pd_mode  = power_down_i | ctrl_reg[CTRL_POWER_DOWN_BIT];
   assign iso_mode = isolate_i | ctrl_reg[CTRL_ISO_BIT];
   assign rpt_mode = repeater_mode_i | vend_reg[VEND_REPEATER_MODE_BIT];

   // power-on stretch: constants only under async reset
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         por_cnt_reg  <= '0;
         por_done_reg <= 1'b0;
      end else if (!por_done_reg) begin
         por_cnt_reg  <= por_cnt_reg + 1'b1;
         por_done_reg <= (por_cnt_reg == ($bits(por_cnt_reg))'(POR_CYCLES - 1));
      end
   end

   // software reset is a one-cycle pulse; internal reset covers all sources
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         soft_rst_reg <= 1'b0;
      end else begin
         soft_rst_reg <= reg_wr_i && reg_addr_i == CTRL_ADDR && reg_wdata_i[CTRL_RESET_BIT];
      end
   end
   assign int_rst = !por_done_reg | soft_rst_reg;

   // control and vendor registers; isolate bit loaded from strap on internal reset, cleared on async reset
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         ctrl_reg <= 16'h0000;
         vend_reg <= VEND_RESET;
      end else if (int_rst) begin
         ctrl_reg <= 16'h0000;
         ctrl_reg[CTRL_ISO_BIT] <= isolate_default_strap_i;
         vend_reg <= VEND_RESET;
      end else if (reg_wr_i) begin
         if (reg_addr_i == CTRL_ADDR) begin
            ctrl_reg[CTRL_POWER_DOWN_BIT] <= reg_wdata_i[CTRL_POWER_DOWN_BIT];
            ctrl_reg[CTRL_ISO_BIT]   <= reg_wdata_i[CTRL_ISO_BIT];
         end
         if (reg_addr_i == VEND_ADDR) begin
            vend_reg[VEND_REPEATER_MODE_BIT]  <= reg_wdata_i[VEND_REPEATER_MODE_BIT];
         end
      end
   end

   // read mux stays live during power-down and isolation
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         reg_rdata_o <= 16'h0000;
      end else if (reg_rd_i) begin
         case (reg_addr_i)
            CTRL_ADDR: begin
               reg_rdata_o <= ctrl_reg;
               reg_rdata_o[CTRL_ANEN_BIT]   <= autoneg_ability_strap_i;
               reg_rdata_o[CTRL_SPEED_BIT]  <= abil[2] | abil[3];
               reg_rdata_o[CTRL_DUPLEX_BIT] <= abil[1] | abil[3];
            end
            STAT_ADDR: begin
               reg_rdata_o <= 16'h0000;
               reg_rdata_o[STAT_ABIL_LSB +: 4] <= abil;
               reg_rdata_o[STAT_AUTONEG_ABILITY_STRAP_BIT] <= autoneg_ability_strap_i;
               reg_rdata_o[STAT_EXT_BIT]   <= 1'b1;
            end
            // abilities sit in the low technology field, the selector below them
            ADV_ADDR: begin
               reg_rdata_o <= 16'h0000;
               reg_rdata_o[ADV_ABIL_LSB +: 4] <= abil;
               reg_rdata_o[4:0] <= ADV_SELECTOR;
            end
            VEND_ADDR: reg_rdata_o <= vend_reg;
            default:   reg_rdata_o <= 16'h0000;
         endcase
      end else begin
         reg_rdata_o <= 16'h0000;
      end
   end

   // mode outputs; strap low forces manual selection from technology code
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         chip_reset_o     <= 1'b1;
         power_down_o     <= 1'b0;
         autoneg_enable_o <= 1'b0;
         speed_100_o      <= 1'b0;
         full_duplex_o    <= 1'b0;
         repeater_o       <= 1'b0;
         mii_oe_n_o       <= 1'b1;
      end else begin
         chip_reset_o     <= int_rst;
         power_down_o     <= pd_mode;
         autoneg_enable_o <= autoneg_ability_strap_i && !pd_mode;
         speed_100_o      <= !autoneg_ability_strap_i && (abil[2] | abil[3]);
         full_duplex_o    <= !autoneg_ability_strap_i && !rpt_mode
                             && (abil[1] | abil[3]);
         repeater_o       <= rpt_mode;
         mii_oe_n_o       <= iso_mode | int_rst;
      end
   end

   // carrier and collision; powered-down logic drives them low
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         crs_o <= 1'b0;
         col_o <= 1'b0;
      end else begin
         crs_o <= !pd_mode && (rx_active_i || (tx_active_i && !rpt_mode));
         col_o <= !pd_mode && (collision_i || (sqe_test_i && !rpt_mode));
      end
   end

   // assertions
   // soft reset runs in two steps: the write, then the internal pulse
   sequence s_soft_write;
      reg_wr_i && reg_addr_i == CTRL_ADDR && reg_wdata_i[CTRL_RESET_BIT];
   endsequence
   sequence s_reset_pulse;
      soft_rst_reg ##1 chip_reset_o;
   endsequence

   a_iso_enable: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      iso_mode |=> mii_oe_n_o) else $error("MII driven while isolated");
   a_ctrl_iso: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      ctrl_reg[CTRL_ISO_BIT] |=> mii_oe_n_o) else $error("iso bit ignored");
   a_pd_pin: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      power_down_i |=> power_down_o) else $error("power-down pin ignored");
   a_pd_bit: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      ctrl_reg[CTRL_POWER_DOWN_BIT] |=> power_down_o) else $error("power-down bit ignored");
   a_soft_reset: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      s_soft_write |=> s_reset_pulse)
      else $error("soft reset missed");
   a_iso_strap: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      soft_rst_reg |=> ctrl_reg[CTRL_ISO_BIT] == $past(isolate_default_strap_i))
      else $error("iso default wrong");
   a_rpt_crs: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      rpt_mode && !rx_active_i |=> !crs_o) else $error("repeater carrier from tx");
   a_rpt_nofd: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      rpt_mode |=> !full_duplex_o) else $error("full duplex in repeater");
   a_rpt_sqe: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      rpt_mode && !collision_i |=> !col_o) else $error("sqe in repeater");
   a_autoneg_ability_strap_stat: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      reg_rd_i && reg_addr_i == STAT_ADDR |=> reg_rdata_o[STAT_AUTONEG_ABILITY_STRAP_BIT] == $past(autoneg_ability_strap_i))
      else $error("status bit 3 wrong");
   a_rd_pd: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      reg_rd_i && reg_addr_i == VEND_ADDR && pd_mode |=> reg_rdata_o == $past(vend_reg))
      else $error("read lost in power-down");

   // power-on stretch must keep the chip in reset until the counter ends
   a_por_hold: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      !por_done_reg |=> chip_reset_o) else $error("reset released during power-on stretch");

   // MII stays released while any internal reset is active
   a_rst_mii: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      int_rst |=> mii_oe_n_o) else $error("MII driven during reset");

   // powered-down logic must not show carrier or collision
   a_pd_quiet: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      pd_mode |=> !crs_o && !col_o) else $error("activity shown while powered down");

   // auto-negotiation is off while powered down
   a_pd_anen: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      pd_mode |=> !autoneg_enable_o) else $error("autoneg on while powered down");

   // strap high with power on enables auto-negotiation
   a_an_enable: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      autoneg_ability_strap_i && !pd_mode |=> autoneg_enable_o) else $error("autoneg not enabled");

   // manual speed and duplex only apply with the strap low
   a_an_manual: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      autoneg_ability_strap_i |=> !speed_100_o && !full_duplex_o) else $error("manual mode with autoneg");

   // repeater pin alone selects repeater mode
   a_rpt_pin: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      repeater_mode_i |=> repeater_o) else $error("repeater pin ignored");

   // vendor bit alone selects repeater mode
   a_rpt_bit: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      vend_reg[VEND_REPEATER_MODE_BIT] |=> repeater_o) else $error("repeater bit ignored");

   // outside repeater mode and power-down, transmit activity alone raises carrier
   a_crs_tx: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      !rpt_mode && !pd_mode && tx_active_i |=> crs_o) else $error("carrier missing on transmit");

   // real collisions pass whenever powered up, repeater or not
   a_col_pass: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      !pd_mode && collision_i |=> col_o) else $error("collision not shown");

   // read data stands only in the cycle after a read
   a_rdata_idle: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      !reg_rd_i |=> reg_rdata_o == 16'h0000) else $error("read data outside its cycle");

   // full strap code reports all four abilities when not a repeater
   a_tech_all: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      reg_rd_i && reg_addr_i == STAT_ADDR && technology_select_strap_i == TECH_ALL && !rpt_mode
      |=> reg_rdata_o[STAT_ABIL_LSB +: 4] == 4'hF) else $error("full ability set missing");

   // advertisement carries the abilities in its technology field
   a_adv_abil: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      reg_rd_i && reg_addr_i == ADV_ADDR |=> reg_rdata_o[ADV_ABIL_LSB +: 4] == $past(abil))
      else $error("advertised abilities misplaced");

   // advertisement selector is fixed
   a_adv_sel: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      reg_rd_i && reg_addr_i == ADV_ADDR |=> reg_rdata_o[4:0] == ADV_SELECTOR)
      else $error("advertisement selector wrong");

   // status reflects abilities; a wrong field would hide the strap setting
   a_stat_abil: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      reg_rd_i && reg_addr_i == STAT_ADDR |=> reg_rdata_o[STAT_ABIL_LSB +: 4] == $past(abil))
      else $error("status abilities wrong");

   // repeater removes full duplex from every reflected ability
   a_rpt_abil: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      rpt_mode |-> abil[1] == 1'b0 && abil[3] == 1'b0) else $error("full duplex ability in repeater");
endmodule

// File: tb/mac_side_model.sv
// MAC-side activity source feeding the datapath activity inputs
module mac_side_model (
   // clock and requests from the bench
   input  wire logic sys_clk_i,
   input  wire logic [3:0] req_i,
   // activity seen by the control block
   output logic       tx_active_o,
   output logic       rx_active_o,
   output logic       collision_o,
   output logic       sqe_test_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // registered so activity changes just after an edge, like real datapath flops
   always_ff @(posedge sys_clk_i) begin
      {sqe_test_o, collision_o, rx_active_o, tx_active_o} <= req_i;
   end
endmodule

// File: tb/testbench.sv
// self-checking bench for the strap and mode control block
module testbench;
   import phy_mode_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk, rst, pd, iso, iso_strap, an_strap, rpt;
   logic [2:0] tech;
   logic [4:0] addr;
   logic [15:0] wdata, rdata, d;
   logic wr, rd, txa, rxa, col_in, sqe, chip_reset, pd_o, an_o, spd_o, fd_o, rpt_o, oe_n, crs, col;
   logic [3:0] act_req, e;
   int n_fail, total_checks, cyc;
   phy_mode_ctrl phy_mode_ctrl_i (.sys_clk_i(sys_clk), .rst_i(rst), .power_down_i(pd), .isolate_i(iso),
      .isolate_default_strap_i(iso_strap), .autoneg_ability_strap_i(an_strap), .technology_select_strap_i(tech),
      .repeater_mode_i(rpt), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
      .reg_rdata_o(rdata), .tx_active_i(txa), .rx_active_i(rxa), .collision_i(col_in), .sqe_test_i(sqe),
      .chip_reset_o(chip_reset), .power_down_o(pd_o), .autoneg_enable_o(an_o), .speed_100_o(spd_o),
      .full_duplex_o(fd_o), .repeater_o(rpt_o), .mii_oe_n_o(oe_n), .crs_o(crs), .col_o(col));
   mac_side_model mac_side_model_i (.sys_clk_i(sys_clk), .req_i(act_req), .tx_active_o(txa),
      .rx_active_o(rxa), .collision_o(col_in), .sqe_test_o(sqe));
   // ability nibble {100F,100H,10F,10H}; repeater strips the full-duplex half
   function automatic logic [3:0] exp_abil(input logic [2:0] c, input logic r);
      logic [3:0] t [8];
      t = '{4'h0, 4'h1, 4'h4, 4'h5, 4'h3, 4'hC, 4'h0, 4'hF};
      return r ? (t[c] & 4'h5) : t[c];
   endfunction
   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic end_of_test();
      if (n_fail == 0 && total_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic reg_wr(input logic [4:0] a, input logic [15:0] v);
      @(posedge sys_clk);
      addr <= a; wdata <= v; wr <= 1'b1;
      @(posedge sys_clk);
      wr <= 1'b0;
   endtask
   task automatic reg_rd(input logic [4:0] a, output logic [15:0] v);
      @(posedge sys_clk);
      addr <= a; rd <= 1'b1;
      @(posedge sys_clk);
      rd <= 1'b0;
      #1 v = rdata;
   endtask
   // mode outputs trail their cause by a cycle; the activity model adds one more
   task automatic settle();
      repeat (4) @(posedge sys_clk);
      #1;
   endtask
   task automatic wait_ready();
      int k;
      for (k = 0; k < 200 && chip_reset !== 1'b0; k++) @(posedge sys_clk);
      #1 chk("chip_reset_o", 16'h0, {15'h0, chip_reset});
   endtask
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   // hang guard: whole sequence needs well under a few thousand cycles
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         end_of_test();
      end
   end
   initial begin
      int i;
      void'($urandom(54758));
      {rst, pd, iso, rpt, addr, wdata, wr, rd, act_req} = '0;
      rst = 1'b1;
      iso_strap = 1'b1;
      an_strap = 1'($urandom());
      tech = 3'h7;
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      wait_ready();
      reg_rd(CTRL_ADDR, d);
      chk("ctrl_iso", 16'h1, {15'h0, d[CTRL_ISO_BIT]});
      chk("mii_oe_n_o", 16'h1, {15'h0, oe_n});
      reg_wr(CTRL_ADDR, 16'h0000);
      settle();
      chk("mii_oe_n_o", 16'h0, {15'h0, oe_n});
      for (i = 0; i < 16; i++) begin
         tech <= i[2:0];
         an_strap <= 1'($urandom());
         rpt <= i[3];
         settle();
         e = exp_abil(tech, rpt);
         reg_rd(CTRL_ADDR, d);
         chk("ctrl_speed", {15'h0, e[2] | e[3]}, {15'h0, d[CTRL_SPEED_BIT]});
         chk("ctrl_duplex", {15'h0, e[1] | e[3]}, {15'h0, d[CTRL_DUPLEX_BIT]});
         chk("speed_100_o", {15'h0, !an_strap && (e[2] | e[3])}, {15'h0, spd_o});
         chk("full_duplex_man", {15'h0, !an_strap && !rpt && (e[1] | e[3])}, {15'h0, fd_o});
         reg_rd(STAT_ADDR, d);
         chk("stat_abil", {12'h0, exp_abil(tech, rpt)}, {12'h0, d[14:11]});
         chk("stat_autoneg_ability_strap", {15'h0, an_strap}, {15'h0, d[STAT_AUTONEG_ABILITY_STRAP_BIT]});
         reg_rd(ADV_ADDR, d);
         chk("adv_abil", {12'h0, exp_abil(tech, rpt)}, {12'h0, d[8:5]});
         chk("autoneg_enable_o", {15'h0, an_strap}, {15'h0, an_o});
         chk("repeater_o", {15'h0, rpt}, {15'h0, rpt_o});
         if (rpt) chk("full_duplex_o", 16'h0, {15'h0, fd_o});
      end
      rpt <= 1'b0;
      reg_wr(VEND_ADDR, 16'h8000);
      act_req <= 4'b1001;
      settle();
      chk("repeater_o", 16'h1, {15'h0, rpt_o});
      chk("crs_o", 16'h0, {15'h0, crs});
      chk("col_o", 16'h0, {15'h0, col});
      reg_wr(VEND_ADDR, 16'h0000);
      settle();
      chk("crs_o", 16'h1, {15'h0, crs});
      chk("col_o_sqe", 16'h1, {15'h0, col});
      iso <= 1'b1;
      settle();
      chk("mii_oe_n_o", 16'h1, {15'h0, oe_n});
      iso <= 1'b0;
      pd <= 1'b1;
      settle();
      chk("power_down_o", 16'h1, {15'h0, pd_o});
      reg_rd(STAT_ADDR, d);
      chk("stat_autoneg_ability_strap_pd", {15'h0, an_strap}, {15'h0, d[STAT_AUTONEG_ABILITY_STRAP_BIT]});
      reg_rd(VEND_ADDR, d);
      chk("vend_pd", 16'h0000, d);
      pd <= 1'b0;
      reg_wr(CTRL_ADDR, 16'h0800);
      settle();
      chk("power_down_o", 16'h1, {15'h0, pd_o});
      reg_rd(5'h1F, d);
      chk("unmapped", 16'h0000, d);
      iso_strap <= 1'b0;
      reg_wr(CTRL_ADDR, 16'h8000);
      #1 chk("chip_reset_early", 16'h0, {15'h0, chip_reset});
      @(posedge sys_clk);
      #1 chk("soft_reset", 16'h1, {15'h0, chip_reset});
      wait_ready();
      reg_rd(CTRL_ADDR, d);
      chk("ctrl_after_reset", 16'h0, {14'h0, d[CTRL_POWER_DOWN_BIT], d[CTRL_ISO_BIT]});
      reg_rd(VEND_ADDR, d);
      chk("vend_after_reset", VEND_RESET, d);
      end_of_test();
   end
endmodule
